/* File: inc/ecs_map.svh */
`ifndef ECS_MAP_SVH
`define ECS_MAP_SVH

// register addresses on the cpu data bus
`define ECS_ADDR_MAIN_CTRL 12'hED0
`define ECS_ADDR_AUX_CTRL  12'hED1
`define ECS_ADDR_STATUS    12'hED2
`define ECS_ADDR_RDPTR_LO  12'hED3
`define ECS_ADDR_RDPTR_HI  12'hED4
`define ECS_ADDR_WRPTR_LO  12'hED5
`define ECS_ADDR_WRPTR_HI  12'hED6
`define ECS_ADDR_DATA_PORT 12'hED7
`define ECS_ADDR_PKT_COUNT 12'hED8

// mac and management register windows
`define ECS_MAC_LO0 12'hE80
`define ECS_MAC_HI0 12'hE85
`define ECS_MAC_ONE 12'hE8A
`define ECS_MAC_LO1 12'hEA0
`define ECS_MAC_HI1 12'hEB9

// main control fields
`define ECS_BIT_TX_HOLD  7
`define ECS_BIT_RX_HOLD  6
`define ECS_BIT_DMA_GO   5
`define ECS_BIT_DMA_SUM  4
`define ECS_BIT_TX_REQ   3
`define ECS_BIT_RX_EN    2

// aux control fields
`define ECS_BIT_AUTO     7
`define ECS_BIT_PKT_DEC  6
`define ECS_BIT_MOD_ON   5

// status fields
`define ECS_BIT_BUF_FLT  6
`define ECS_BIT_RX_ACT   2
`define ECS_BIT_TX_ABT   1
`define ECS_BIT_PHY_RDY  0

// power-on values
`define ECS_RST_MAIN_CTRL 8'h00
`define ECS_RST_AUX_CTRL  8'h80
`define ECS_RST_STATUS    8'h00

`endif

/* File: inc/ecs_pkg.sv */
package ecs_pkg;

    localparam int PTR_W = 13;
    localparam int CNT_W = 8;

    // state of the control bank apart from the two sticky status flags
    typedef struct packed {
        logic             txHold;
        logic             rxHold;
        logic             dmaGo;
        logic             dmaSum;
        logic             txReq;
        logic             rx_accept_enable;
        logic             autoStep;
        logic             pending_count_decrement;
        logic             modOn;
        logic [PTR_W-1:0] rdPtr;
        logic [PTR_W-1:0] wrPtr;
        logic [CNT_W-1:0] pktCnt;
        logic [7:0]       rdData;
        logic             bufWrStb;
        logic [7:0]       bufWrData;
        logic [PTR_W-1:0] bufWrAddr;
        logic             bufRdStb;
        logic             txErrIrq;
        logic             rxErrIrq;
        logic             rxDrop;
    } ecs_state_t;

    // state of one sticky status flag
    typedef struct packed {
        logic flag;
    } ecs_flag_state_t;

endpackage : ecs_pkg

/* File: design/ecs_sticky_flag.sv */
`timescale 1ns/1ps
`default_nettype none

module ecs_sticky_flag (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic setEv,
    input  wire logic clrEv,
    output var  logic flag
);

    ecs_pkg::ecs_flag_state_t stateReg;
    ecs_pkg::ecs_flag_state_t stateNext;

    always_comb begin
        stateNext = stateReg;
        if (setEv) begin
            stateNext.flag = 1'b1;
        end else if (clrEv) begin
            stateNext.flag = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stateReg <= '0;
        end else if (ce) begin
            stateReg <= stateNext;
        end
    end

    assign flag = stateReg.flag;

    // set in the clear cycle must survive
    set_wins_a : assert property (@(posedge clk) disable iff (rst)
        ce && setEv && clrEv |=> flag)
        else $error("flag lost when set met clear");

    // flag holds without a clear
    flag_holds_a : assert property (@(posedge clk) disable iff (rst)
        flag && !(ce && clrEv) |=> flag)
        else $error("flag dropped without clear");

endmodule : ecs_sticky_flag

`default_nettype wire

/* File: design/ecs_top_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecs_map.svh"

module ecs_top_ctrl #(
    parameter int BUF_BYTES = 8192
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     ce,
    input  wire logic [11:0]              addr,
    input  wire logic                     wrEn,
    input  wire logic                     rdEn,
    input  wire logic [7:0]               wrData,
    output var  logic [7:0]               rdData,
    output var  logic                     macMiiRd,
    output var  logic                     macMiiWr,
    output var  logic [ecs_pkg::PTR_W-1:0] bufRdAddr,
    input  wire logic [7:0]               bufRdData,
    output var  logic                     bufRdStrobe,
    output var  logic                     bufWrStrobe,
    output var  logic [ecs_pkg::PTR_W-1:0] bufWrAddr,
    output var  logic [7:0]               bufWrData,
    output var  logic                     txLogicReset,
    output var  logic                     rxLogicReset,
    output var  logic                     dmaGoBusy,
    output var  logic                     dmaSumSelect,
    output var  logic                     txSendRequest,
    output var  logic                     rxAcceptEnable,
    output var  logic                     moduleOn,
    output var  logic [ecs_pkg::CNT_W-1:0] pendingPacketCount,
    input  wire logic                     dmaDone,
    input  wire logic                     txDone,
    input  wire logic                     txAbortEv,
    input  wire logic                     bufFaultEv,
    input  wire logic                     arbFailTx,
    input  wire logic                     arbFailRx,
    input  wire logic                     rx_active_flag,
    input  wire logic                     phyTimerDone,
    input  wire logic                     rxPacketDone,
    output var  logic                     txErrorIrqSet,
    output var  logic                     rxErrorIrqSet,
    output var  logic                     rxPacketDrop,
    output var  logic                     bufferFaultFlag,
    output var  logic                     txAbortFlag
);

    localparam int PW = ecs_pkg::PTR_W;
    localparam int CW = ecs_pkg::CNT_W;
    localparam logic [PW-1:0] PTR_LAST = PW'(BUF_BYTES - 1);
    localparam logic [CW-1:0] CNT_MAX  = '1;
    localparam logic [7:0]    AUX_RST  = `ECS_RST_AUX_CTRL;

    // pointer width must cover the buffer
    if (BUF_BYTES < 2 || BUF_BYTES > (1 << PW)) begin : gBadSize
        $error("BUF_BYTES must lie between 2 and 2**PTR_W");
    end

    ecs_pkg::ecs_state_t stateReg;
    ecs_pkg::ecs_state_t stateNext;

    // access decode
    logic hitMain;
    logic hitAux;
    logic hitStat;
    logic hitData;
    logic macHit;
    logic wrMain;
    logic wrAux;
    logic wrStat;
    logic rdDataPort;
    logic wrDataPort;
    logic pktDecDo;

    assign hitMain    = (addr == `ECS_ADDR_MAIN_CTRL);
    assign hitAux     = (addr == `ECS_ADDR_AUX_CTRL);
    assign hitStat    = (addr == `ECS_ADDR_STATUS);
    assign hitData    = (addr == `ECS_ADDR_DATA_PORT);
    assign wrMain     = wrEn && hitMain;
    assign wrAux      = wrEn && hitAux;
    assign wrStat     = wrEn && hitStat;
    assign rdDataPort = rdEn && hitData;
    assign wrDataPort = wrEn && hitData;
    assign pktDecDo   = stateReg.pending_count_decrement && (stateReg.pktCnt != '0);

    assign macHit = ((addr >= `ECS_MAC_LO0) && (addr <= `ECS_MAC_HI0))
                 || (addr == `ECS_MAC_ONE)
                 || ((addr >= `ECS_MAC_LO1) && (addr <= `ECS_MAC_HI1));

    // strobes rely on host spacing and module on
    assign macMiiRd = rdEn && macHit;
    assign macMiiWr = wrEn && macHit;

    // sticky status flags
    logic bufFaultSet;
    logic txAbortSet;

    assign bufFaultSet = bufFaultEv || arbFailTx || arbFailRx;
    assign txAbortSet  = txAbortEv;

    ecs_sticky_flag uBufFault (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .setEv (bufFaultSet),
        .clrEv (wrStat && !wrData[`ECS_BIT_BUF_FLT]),
        .flag  (bufferFaultFlag)
    );

    ecs_sticky_flag uTxAbort (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .setEv (txAbortSet),
        .clrEv (wrStat && !wrData[`ECS_BIT_TX_ABT]),
        .flag  (txAbortFlag)
    );

    // pointer step with wrap at buffer end
    function automatic logic [PW-1:0] stepPtr(input logic [PW-1:0] p);
        stepPtr = (p >= PTR_LAST) ? '0 : p + PW'(1);
    endfunction : stepPtr

    function automatic logic [7:0] readMux(input ecs_pkg::ecs_state_t s,
                                           input logic [11:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `ECS_ADDR_MAIN_CTRL: begin
                v[`ECS_BIT_TX_HOLD] = s.txHold;
                v[`ECS_BIT_RX_HOLD] = s.rxHold;
                v[`ECS_BIT_DMA_GO]  = s.dmaGo;
                v[`ECS_BIT_DMA_SUM] = s.dmaSum;
                v[`ECS_BIT_TX_REQ]  = s.txReq;
                v[`ECS_BIT_RX_EN]   = s.rx_accept_enable;
            end
            `ECS_ADDR_AUX_CTRL: begin
                v[`ECS_BIT_AUTO]    = s.autoStep;
                v[`ECS_BIT_PKT_DEC] = s.pending_count_decrement;
                v[`ECS_BIT_MOD_ON]  = s.modOn;
            end
            `ECS_ADDR_STATUS: begin
                v[`ECS_BIT_BUF_FLT] = bufferFaultFlag;
                v[`ECS_BIT_RX_ACT]  = rx_active_flag;
                v[`ECS_BIT_TX_ABT]  = txAbortFlag;
                v[`ECS_BIT_PHY_RDY] = phyTimerDone;
            end
            `ECS_ADDR_RDPTR_LO: v = s.rdPtr[7:0];
            `ECS_ADDR_RDPTR_HI: v = 8'(s.rdPtr[PW-1:8]);
            `ECS_ADDR_WRPTR_LO: v = s.wrPtr[7:0];
            `ECS_ADDR_WRPTR_HI: v = 8'(s.wrPtr[PW-1:8]);
            `ECS_ADDR_DATA_PORT: v = bufRdData;
            `ECS_ADDR_PKT_COUNT: v = 8'(s.pktCnt);
            default: v = 8'h00;
        endcase
        readMux = v;
    endfunction : readMux

    // next state of the bank
    always_comb begin
        stateNext          = stateReg;
        stateNext.bufWrStb = 1'b0;
        stateNext.bufRdStb = rdDataPort;
        stateNext.txErrIrq = arbFailTx;
        stateNext.rxErrIrq = arbFailRx;
        stateNext.rxDrop   = arbFailRx;
        if (rdEn) begin
            stateNext.rdData = readMux(stateReg, addr);
        end

        if (dmaDone) begin
            stateNext.dmaGo = 1'b0;
        end
        if (txDone || txAbortEv || arbFailTx) begin
            stateNext.txReq = 1'b0;
        end

        stateNext.pending_count_decrement = 1'b0;
        if (pktDecDo && !rxPacketDone) begin
            stateNext.pktCnt = stateReg.pktCnt - CW'(1);
        end else if (rxPacketDone && !pktDecDo && stateReg.pktCnt != CNT_MAX) begin
            stateNext.pktCnt = stateReg.pktCnt + CW'(1);
        end

        // software writes to control, low bits dropped
        if (wrMain) begin
            stateNext.txHold = wrData[`ECS_BIT_TX_HOLD];
            stateNext.rxHold = wrData[`ECS_BIT_RX_HOLD];
            stateNext.dmaGo  = wrData[`ECS_BIT_DMA_GO];
            stateNext.dmaSum = wrData[`ECS_BIT_DMA_SUM];
            stateNext.txReq  = wrData[`ECS_BIT_TX_REQ];
            stateNext.rx_accept_enable   = wrData[`ECS_BIT_RX_EN];
        end
        if (wrAux) begin
            stateNext.autoStep = wrData[`ECS_BIT_AUTO];
            stateNext.pending_count_decrement   = wrData[`ECS_BIT_PKT_DEC];
            stateNext.modOn    = wrData[`ECS_BIT_MOD_ON];
        end

        // pointer byte writes
        if (wrEn && addr == `ECS_ADDR_RDPTR_LO) begin
            stateNext.rdPtr[7:0] = wrData;
        end
        if (wrEn && addr == `ECS_ADDR_RDPTR_HI) begin
            stateNext.rdPtr[PW-1:8] = wrData[PW-9:0];
        end
        if (wrEn && addr == `ECS_ADDR_WRPTR_LO) begin
            stateNext.wrPtr[7:0] = wrData;
        end
        if (wrEn && addr == `ECS_ADDR_WRPTR_HI) begin
            stateNext.wrPtr[PW-1:8] = wrData[PW-9:0];
        end

        if (rdDataPort && stateReg.autoStep) begin
            stateNext.rdPtr = stepPtr(stateReg.rdPtr);
        end
        if (wrDataPort) begin
            stateNext.bufWrStb  = 1'b1;
            stateNext.bufWrData = wrData;
            stateNext.bufWrAddr = stateReg.wrPtr;
            if (stateReg.autoStep) begin
                stateNext.wrPtr = stepPtr(stateReg.wrPtr);
            end
        end

        // held transmit logic cannot keep a request
        if (stateNext.txHold) begin
            stateNext.txReq = 1'b0;
        end
    end

    // registers, reset ignores clock enable
    always_ff @(posedge clk) begin
        if (rst) begin
            stateReg          <= '0;
            stateReg.autoStep <= AUX_RST[`ECS_BIT_AUTO];
        end else if (ce) begin
            stateReg <= stateNext;
        end
    end

    // outputs straight from flops, except rxAcceptEnable which is gated by receive hold
    assign rdData             = stateReg.rdData;
    assign bufRdAddr          = stateReg.rdPtr;
    assign bufRdStrobe        = stateReg.bufRdStb;
    assign bufWrStrobe        = stateReg.bufWrStb;
    assign bufWrAddr          = stateReg.bufWrAddr;
    assign bufWrData          = stateReg.bufWrData;
    assign txLogicReset       = stateReg.txHold;
    assign rxLogicReset       = stateReg.rxHold;
    assign dmaGoBusy          = stateReg.dmaGo;
    assign dmaSumSelect       = stateReg.dmaSum;
    assign txSendRequest      = stateReg.txReq;
    assign rxAcceptEnable     = stateReg.rx_accept_enable && !stateReg.rxHold;
    assign moduleOn           = stateReg.modOn;
    assign pendingPacketCount = stateReg.pktCnt;
    assign txErrorIrqSet      = stateReg.txErrIrq;
    assign rxErrorIrqSet      = stateReg.rxErrIrq;
    assign rxPacketDrop       = stateReg.rxDrop;

    // helper for the decrement check
    logic [CW-1:0] cntBefore;
    always_ff @(posedge clk) begin
        cntBefore <= stateReg.pktCnt;
    end

    tx_hold_a : assert property (@(posedge clk) disable iff (rst)
        ce && wrMain && wrData[`ECS_BIT_TX_HOLD] |=> txLogicReset && !txSendRequest)
        else $error("transmit hold not applied");

    rx_hold_a : assert property (@(posedge clk) disable iff (rst)
        ce && wrMain && wrData[`ECS_BIT_RX_HOLD] |=> rxLogicReset && !rxAcceptEnable)
        else $error("receive hold not applied");

    dma_end_a : assert property (@(posedge clk) disable iff (rst)
        ce && dmaDone && !wrMain |=> !dmaGoBusy)
        else $error("dma go not cleared at end");

    dma_mode_a : assert property (@(posedge clk) disable iff (rst)
        ce && wrMain |=> dmaSumSelect == $past(wrData[`ECS_BIT_DMA_SUM]))
        else $error("dma mode not stored");

    send_end_a : assert property (@(posedge clk) disable iff (rst)
        ce && txDone && !wrMain |=> !txSendRequest)
        else $error("send request not cleared");

    low_bits_a : assert property (@(posedge clk) disable iff (rst)
        ce && rdEn && hitMain |=> rdData[1:0] == 2'b00)
        else $error("unused control bits not zero");

    ptr_step_a : assert property (@(posedge clk) disable iff (rst)
        ce && rdDataPort && stateReg.autoStep && stateReg.rdPtr != PTR_LAST
        && !(wrEn && addr == `ECS_ADDR_RDPTR_LO)
        |=> bufRdAddr == $past(bufRdAddr) + PW'(1))
        else $error("read pointer did not step");

    pkt_dec_a : assert property (@(posedge clk) disable iff (rst)
        ce && wrAux && wrData[`ECS_BIT_PKT_DEC] && pendingPacketCount != '0
        && !rxPacketDone ##1 ce && !rxPacketDone && !wrAux
        |=> pendingPacketCount == cntBefore - CW'(1) && !stateReg.pending_count_decrement)
        else $error("packet count not lowered by one");

    mod_on_a : assert property (@(posedge clk) disable iff (rst)
        ce && wrAux |=> moduleOn == $past(wrData[`ECS_BIT_MOD_ON]))
        else $error("module on not stored");

    busy_read_a : assert property (@(posedge clk) disable iff (rst)
        ce && rdEn && hitStat |=> rdData[`ECS_BIT_RX_ACT] == $past(rx_active_flag))
        else $error("receive busy readback wrong");

    phy_read_a : assert property (@(posedge clk) disable iff (rst)
        ce && rdEn && hitStat |=> rdData[`ECS_BIT_PHY_RDY] == $past(phyTimerDone))
        else $error("phy ready readback wrong");

    mac_window_a : assert property (@(posedge clk) disable iff (rst)
        (macMiiRd || macMiiWr) |-> (addr[11:8] == 4'hE) && !hitMain && !hitData)
        else $error("mac strobe outside window");

    arb_fail_a : assert property (@(posedge clk) disable iff (rst)
        ce && arbFailRx |=> rxErrorIrqSet && rxPacketDrop && bufferFaultFlag)
        else $error("arbitration failure not reported");

endmodule : ecs_top_ctrl

`default_nettype wire

/* File: testbench/ecs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecs_map.svh"

// cpu side of the register bus, one access at a time
module ecs_host_model (
    input  wire logic        clk,
    input  wire logic        moduleOn,
    input  wire logic [7:0]  rdData,
    output var  logic [11:0] addr,
    output var  logic        wrEn,
    output var  logic        rdEn,
    output var  logic [7:0]  wrData
);
    // idle bus at time zero
    initial begin
        addr = 12'h000;
        wrEn = 1'b0;
        rdEn = 1'b0;
        wrData = 8'h00;
    end

    function automatic logic isMac(input logic [11:0] a);
        return (a >= `ECS_MAC_LO0 && a <= `ECS_MAC_HI0) || a == `ECS_MAC_ONE
            || (a >= `ECS_MAC_LO1 && a <= `ECS_MAC_HI1);
    endfunction : isMac

    // one access: drive after a falling edge, taken at the rising edge
    task automatic access(input logic wr, input logic [11:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        q = 8'h00;
        // mac window only while module on
        if (isMac(a) && moduleOn !== 1'b1) begin
            $display("host skips mac access while module is off");
        end else begin
            @(negedge clk);
            addr <= a;
            wrData <= d;
            wrEn <= wr;
            rdEn <= !wr;
            @(negedge clk);
            q = rdData;
            wrEn <= 1'b0;
            rdEn <= 1'b0;
            // released lines show the inverse, never the stale value
            addr <= ~a;
            wrData <= ~d;
            // next access waits a full idle cycle
        end
    endtask : access
endmodule : ecs_host_model
`default_nettype wire

/* File: testbench/test_ethernet_top_control_status.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecs_map.svh"

module test_ethernet_top_control_status;
    logic                      clk = 1'b0;
    logic                      rst = 1'b1;
    logic [11:0]               addr;
    logic                      wrEn;
    logic                      rdEn;
    logic [7:0]                wrData;
    logic [7:0]                rdData;
    logic                      macMiiRd;
    logic                      macMiiWr;
    logic [ecs_pkg::PTR_W-1:0] bufRdAddr;
    logic [ecs_pkg::PTR_W-1:0] bufWrAddr;
    logic [7:0]                bufWrData;
    logic                      bufRdStrobe;
    logic                      bufWrStrobe;
    logic                      txLogicReset;
    logic                      rxLogicReset;
    logic                      dmaGoBusy;
    logic                      dmaSumSelect;
    logic                      txSendRequest;
    logic                      rxAcceptEnable;
    logic                      moduleOn;
    logic [ecs_pkg::CNT_W-1:0] pendingPacketCount;
    logic                      txErrorIrqSet;
    logic                      rxErrorIrqSet;
    logic                      rxPacketDrop;
    logic                      bufferFaultFlag;
    logic                      txAbortFlag;
    logic [6:0]                ev = 7'h00; // dma, txdone, abort, fault, arbtx, arbrx, pkt
    logic                      rx_active_flag = 1'b0;
    logic                      phyTimerDone = 1'b0;
    logic                      sawMac = 1'b0;
    logic [7:0]                q;
    int                        n_fail = 0;
    int                        samples_checked = 0;

    always #12.5 clk = ~clk;

    // buffer byte is a fixed scramble of its address
    wire logic [7:0] bufRdData = bufRdAddr[7:0] ^ 8'hA5;

    // remember whether the last access hit the mac window
    always @(posedge clk) if (rdEn || wrEn) sawMac <= macMiiRd || macMiiWr;

    ecs_host_model i_host (.clk(clk), .moduleOn(moduleOn), .rdData(rdData), .addr(addr),
        .wrEn(wrEn), .rdEn(rdEn), .wrData(wrData));

    // small buffer so pointer wrap is reachable
    ecs_top_ctrl #(.BUF_BYTES(16)) i_dut (.clk(clk), .rst(rst), .ce(1'b1), .addr(addr),
        .wrEn(wrEn), .rdEn(rdEn), .wrData(wrData), .rdData(rdData), .macMiiRd(macMiiRd),
        .macMiiWr(macMiiWr), .bufRdAddr(bufRdAddr), .bufRdData(bufRdData),
        .bufRdStrobe(bufRdStrobe), .bufWrStrobe(bufWrStrobe), .bufWrAddr(bufWrAddr),
        .bufWrData(bufWrData), .txLogicReset(txLogicReset), .rxLogicReset(rxLogicReset),
        .dmaGoBusy(dmaGoBusy), .dmaSumSelect(dmaSumSelect), .txSendRequest(txSendRequest),
        .rxAcceptEnable(rxAcceptEnable), .moduleOn(moduleOn),
        .pendingPacketCount(pendingPacketCount), .dmaDone(ev[0]), .txDone(ev[1]),
        .txAbortEv(ev[2]), .bufFaultEv(ev[3]), .arbFailTx(ev[4]), .arbFailRx(ev[5]),
        .rx_active_flag(rx_active_flag), .phyTimerDone(phyTimerDone), .rxPacketDone(ev[6]),
        .txErrorIrqSet(txErrorIrqSet), .rxErrorIrqSet(rxErrorIrqSet),
        .rxPacketDrop(rxPacketDrop), .bufferFaultFlag(bufferFaultFlag),
        .txAbortFlag(txAbortFlag));

    task automatic check(input logic [12:0] seen, input logic [12:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s: %h not %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_host.access(1'b1, a, d, q);
    endtask : wr

    task automatic rdChk(input logic [11:0] a, input logic [7:0] exp, input string msg);
        i_host.access(1'b0, a, 8'h00, q);
        check(q, exp, msg);
    endtask : rdChk

    // one-cycle event pulse, outputs settled when it returns
    task automatic pulse(input int i);
        @(negedge clk);
        ev[i] = 1'b1;
        @(negedge clk);
        ev[i] = 1'b0;
    endtask : pulse

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic t_reset;
        rdChk(`ECS_ADDR_MAIN_CTRL, 8'h00, "main reset");
        rdChk(`ECS_ADDR_AUX_CTRL, 8'h80, "aux reset");
        rdChk(`ECS_ADDR_STATUS, 8'h00, "status reset");
        check(moduleOn, 1'b0, "module off at reset");
        $display("test reset done");
    endtask : t_reset

    task automatic t_main;
        wr(`ECS_ADDR_MAIN_CTRL, 8'hF3);
        check(txLogicReset, 1'b1, "tx hold");
        check(rxLogicReset, 1'b1, "rx hold");
        check(dmaSumSelect, 1'b1, "sum mode");
        check(dmaGoBusy, 1'b1, "dma started");
        rdChk(`ECS_ADDR_MAIN_CTRL, 8'hF0, "main low bits");
        pulse(0);
        check(dmaGoBusy, 1'b0, "dma end");
        rdChk(`ECS_ADDR_MAIN_CTRL, 8'hD0, "dma cleared");
        $display("test main done");
    endtask : t_main

    task automatic t_ctrl;
        wr(`ECS_ADDR_MAIN_CTRL, 8'h0C);
        check(txSendRequest, 1'b1, "send set");
        check(rxAcceptEnable, 1'b1, "rx enabled");
        pulse(1);
        check(txSendRequest, 1'b0, "send done");
        wr(`ECS_ADDR_MAIN_CTRL, 8'h0C);
        pulse(2);
        check(txSendRequest, 1'b0, "send aborted");
        check(txAbortFlag, 1'b1, "abort flag");
        pulse(4);
        check(txErrorIrqSet, 1'b1, "tx arb irq");
        wr(`ECS_ADDR_MAIN_CTRL, 8'h44);
        check(rxAcceptEnable, 1'b0, "held rx refuses");
        $display("test ctrl done");
    endtask : t_ctrl

    task automatic t_status;
        pulse(5);
        check(rxErrorIrqSet, 1'b1, "rx arb irq");
        check(rxPacketDrop, 1'b1, "rx arb drop");
        check(bufferFaultFlag, 1'b1, "fault on arb");
        rdChk(`ECS_ADDR_STATUS, 8'h42, "flags read");
        wr(`ECS_ADDR_STATUS, 8'h42);
        check(bufferFaultFlag, 1'b1, "one keeps fault");
        check(txAbortFlag, 1'b1, "one keeps abort");
        // clear and hardware set land on one edge
        fork
            wr(`ECS_ADDR_STATUS, 8'h00);
            pulse(3);
        join
        check(bufferFaultFlag, 1'b1, "set beats clear");
        check(txAbortFlag, 1'b0, "abort cleared");
        wr(`ECS_ADDR_STATUS, 8'h00);
        check(bufferFaultFlag, 1'b0, "fault cleared");
        @(negedge clk);
        rx_active_flag = 1'b1;
        phyTimerDone = 1'b1;
        rdChk(`ECS_ADDR_STATUS, 8'h05, "busy and phy");
        $display("test status done");
    endtask : t_status

    task automatic t_buffer;
        wr(`ECS_ADDR_RDPTR_LO, 8'h0F);
        wr(`ECS_ADDR_RDPTR_HI, 8'h00);
        rdChk(`ECS_ADDR_DATA_PORT, 8'hAA, "last byte");
        check(bufRdStrobe, 1'b1, "read strobe");
        check(bufRdAddr, 13'h0000, "read wrap");
        rdChk(`ECS_ADDR_DATA_PORT, 8'hA5, "first byte");
        check(bufRdAddr, 13'h0001, "read step");
        wr(`ECS_ADDR_WRPTR_LO, 8'h03);
        wr(`ECS_ADDR_DATA_PORT, 8'h5A);
        check(bufWrStrobe, 1'b1, "write strobe");
        check(bufWrAddr, 13'h0003, "write addr");
        check(bufWrData, 8'h5A, "write data");
        rdChk(`ECS_ADDR_WRPTR_LO, 8'h04, "write step");
        wr(`ECS_ADDR_AUX_CTRL, 8'h00);
        rdChk(`ECS_ADDR_DATA_PORT, 8'hA4, "no step read");
        check(bufRdAddr, 13'h0001, "pointer kept");
        $display("test buffer done");
    endtask : t_buffer

    task automatic t_count;
        pulse(6);
        pulse(6);
        check(pendingPacketCount, 8'h02, "two packets");
        wr(`ECS_ADDR_AUX_CTRL, 8'h40);
        @(negedge clk);
        check(pendingPacketCount, 8'h01, "one decrement");
        rdChk(`ECS_ADDR_AUX_CTRL, 8'h00, "decrement cleared");
        rdChk(`ECS_ADDR_PKT_COUNT, 8'h01, "count read");
        $display("test count done");
    endtask : t_count

    task automatic t_mac;
        wr(`ECS_ADDR_AUX_CTRL, 8'hA0);
        check(moduleOn, 1'b1, "module on");
        rdChk(`ECS_ADDR_AUX_CTRL, 8'hA0, "aux read");
        wr(12'hE80, 8'h00);
        check(sawMac, 1'b1, "window start");
        wr(12'hE86, 8'h00);
        check(sawMac, 1'b0, "gap below E8A");
        wr(12'hE8A, 8'h00);
        check(sawMac, 1'b1, "single address");
        rdChk(12'hEB9, 8'h00, "mac read data");
        check(sawMac, 1'b1, "window end");
        wr(12'hEBA, 8'h00);
        check(sawMac, 1'b0, "past window");
        $display("test mac done");
    endtask : t_mac

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test;
    end

    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_main;
        t_ctrl;
        t_status;
        t_buffer;
        t_count;
        t_mac;
        stop_test;
    end
endmodule : test_ethernet_top_control_status
`default_nettype wire
